// *** rtl/sra_pkg.sv ***
package sra_pkg;
	// register geometry
	localparam int REG_W = 16;
	localparam int ERR_W = 16;
	localparam int NUM_QREG = 5;
	localparam int DEF_ERRQ_DEPTH = 8;
	// register selector codes
	localparam logic [2:0] SEL_QUES = 3'h0;
	localparam logic [2:0] SEL_FREQ = 3'h1;
	localparam logic [2:0] SEL_LIM = 3'h2;
	localparam logic [2:0] SEL_POW = 3'h3;
	localparam logic [2:0] SEL_OPER = 3'h4;
	// field positions
	localparam int FREQ_EXT_REF_BIT = 8;
	localparam int LIM1_FAIL_BIT = 0;
	localparam int LIM2_FAIL_BIT = 1;
	localparam int POW_IF_OVL_BIT = 2;
	localparam int QUES_POW_BIT = 3;
	localparam int QUES_FREQ_BIT = 5;
	localparam int QUES_LIM_BIT = 9;
	localparam int STB_ERRQ_BIT = 2;
	localparam int STB_QUES_BIT = 3;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_RQS_BIT = 6;
	localparam int STB_OPER_BIT = 7;
	localparam int ESR_OPC_BIT = 0;
	localparam int ESR_QYE_BIT = 2;
	localparam int ESR_DDE_BIT = 3;
	localparam int ESR_EXE_BIT = 4;
	localparam int ESR_CME_BIT = 5;
	localparam int ESR_PON_BIT = 7;
	// implemented bits per register, bit 15 always excluded
	localparam logic [15:0] TOP_BIT_CLEAR = 16'h7FFF;
	localparam logic [15:0] MASK_QUES = 16'h0228;
	localparam logic [15:0] MASK_FREQ = 16'h0100;
	localparam logic [15:0] MASK_LIM = 16'h0003;
	localparam logic [15:0] MASK_POW = 16'h0004;
	localparam logic [15:0] MASK_OPER = 16'h0000;
	localparam logic [NUM_QREG-1:0][15:0] QREG_MASK =
		{MASK_OPER, MASK_POW, MASK_LIM, MASK_FREQ, MASK_QUES};
	// status byte bits that can raise a service request
	localparam logic [7:0] SRQ_SRC_MASK = 8'hBC;
	// reset and preset values
	localparam logic [15:0] PTR_PRESET = 16'hFFFF;
	localparam logic [15:0] NTR_PRESET = 16'h0000;
	localparam logic [15:0] ENAB_PRESET = 16'h0000;
	localparam logic [7:0] MASK8_CLEAR = 8'h00;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	// remote commands
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_COND_Q = 5'h01,
		OP_EVENT_Q = 5'h02,
		OP_ENAB_Q = 5'h03,
		OP_PTR_Q = 5'h04,
		OP_NTR_Q = 5'h05,
		OP_ENAB_W = 5'h06,
		OP_PTR_W = 5'h07,
		OP_NTR_W = 5'h08,
		OP_ESE_W = 5'h09,
		OP_ESE_Q = 5'h0A,
		OP_SRE_W = 5'h0B,
		OP_SRE_Q = 5'h0C,
		OP_PPE_W = 5'h0D,
		OP_PPE_Q = 5'h0E,
		OP_STB_Q = 5'h0F,
		OP_ESR_Q = 5'h10,
		OP_ERR_Q = 5'h11,
		OP_CLS = 5'h12,
		OP_STAT_PRESET = 5'h13,
		OP_RST = 5'h14,
		OP_SYS_PRESET = 5'h15
	} sra_op_e;
endpackage

// *** rtl/sra_qreg.sv ***
module sra_qreg #(
	parameter logic [15:0] VALID = 16'hFFFF
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// live condition
	input wire logic [15:0] cond_in,
	// register access
	input wire logic wr_enab,
	input wire logic wr_ptr,
	input wire logic wr_ntr,
	input wire logic [15:0] wdata,
	input wire logic rd_event,
	input wire logic preset,
	input wire logic clr_event,
	// register parts
	output logic [15:0] cond,
	output logic [15:0] event_bits,
	output logic [15:0] enab,
	output logic [15:0] ptr,
	output logic [15:0] ntr,
	output logic summ
);
	localparam logic [15:0] USE = VALID & sra_pkg::TOP_BIT_CLEAR;

	typedef struct packed {
		logic [15:0] prev;
		logic [15:0] evt;
		logic [15:0] enab;
		logic [15:0] ptr;
		logic [15:0] ntr;
	} sra_qreg_s;

	localparam sra_qreg_s QREG_RST = '{
		prev: 16'h0000,
		evt: 16'h0000,
		enab: sra_pkg::ENAB_PRESET & USE,
		ptr: sra_pkg::PTR_PRESET & USE,
		ntr: sra_pkg::NTR_PRESET & USE
	};

	sra_qreg_s st_r;
	sra_qreg_s st_nxt;
	logic [15:0] hit;

	always_comb begin
		st_nxt = st_r;
		// (R2) unused and top bits
		cond = cond_in & USE;
		st_nxt.prev = cond;
		hit = ((cond & ~st_r.prev & st_r.ptr) |
			(~cond & st_r.prev & st_r.ntr)) & USE;
		// (R21) read clears event
		if (rd_event || clr_event) begin
			st_nxt.evt = 16'h0000;
		end
		st_nxt.evt = st_nxt.evt | hit;
		// (R23) unused mask bits
		if (wr_enab) begin
			st_nxt.enab = wdata & USE;
		end
		if (wr_ptr) begin
			st_nxt.ptr = wdata & USE;
		end
		if (wr_ntr) begin
			st_nxt.ntr = wdata & USE;
		end
		// (R14) enables zeroed
		// (R15) filters preset
		if (preset) begin
			st_nxt.enab = sra_pkg::ENAB_PRESET & USE;
			st_nxt.ptr = sra_pkg::PTR_PRESET & USE;
			st_nxt.ntr = sra_pkg::NTR_PRESET & USE;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= QREG_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign event_bits = st_r.evt;
	assign enab = st_r.enab;
	assign ptr = st_r.ptr;
	assign ntr = st_r.ntr;
	// (R22) enabled event summary
	assign summ = |(st_r.evt & st_r.enab);
endmodule

// *** rtl/sra_errq.sv ***
module sra_errq #(
	parameter int DEPTH = sra_pkg::DEF_ERRQ_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// queue control
	input wire logic clr,
	input wire logic push,
	input wire logic [sra_pkg::ERR_W-1:0] push_code,
	input wire logic pop,
	// queue head
	output logic [sra_pkg::ERR_W-1:0] head_code,
	output logic nonempty
);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

	generate
		if (DEPTH < 1 || DEPTH > 255) begin : g_bad_depth
			$error("error queue depth out of range");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][sra_pkg::ERR_W-1:0] mem;
		logic [CNT_W-1:0] cnt;
	} sra_errq_s;

	sra_errq_s st_r;
	sra_errq_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (clr) begin
			st_nxt.cnt = '0;
		end else if (pop && st_r.cnt != '0) begin
			st_nxt.mem = st_r.mem >> sra_pkg::ERR_W;
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
		// (R10) one entry per error
		if (push && st_nxt.cnt != FULL) begin
			st_nxt.mem[st_nxt.cnt] = push_code;
			st_nxt.cnt = st_nxt.cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// (R10) empty answers no error
	assign head_code = (st_r.cnt == '0) ? sra_pkg::ERR_NONE : st_r.mem[0];
	assign nonempty = (st_r.cnt != '0);
endmodule

// *** rtl/sra_top.sv ***
// Notes on behaviour
// (R1) freq bit 8 follows external reference
// (R2) bit 15 reads zero in sub-registers
// (R3) limit bit 0 on limit line 1 fail
// (R4) limit bit 1 on limit line 2 fail
// (R5) power bit 2 and display on overload
// (R6) srq when enabled stb bits 2,3,4,5,7 set
// (R7) ese 1 plus sre 32 gives opc srq
// (R8) controller should set all enable bits
// (R9) queries return the raw bit pattern
// (R10) error queue fifo, empty returns zero
// (R11) controller should read errors after srq
// (R12) serial poll returns status byte directly
// (R13) cls or flagged power-on clears events
// (R14) preset zeroes enables and ntr, ptr all ones
// (R15) preset sets ptr ones, ntr zero
// (R16) sre ese ppe cleared only flagged power-on
// (R17) power-on, device clear flush buffers
// (R18) rst, sys preset, stat preset or cls clears output buffer at line start
// (R19) device clear keeps instrument settings
// (R20) reset command leaves status untouched
// (R21) event read clears, condition read not
// (R22) enabled event raises summary bit
// (R23) unused bits read zero, ignore writes
module sra_top #(
	parameter int ERRQ_DEPTH = sra_pkg::DEF_ERRQ_DEPTH
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// power-on and device clear
	input wire logic por_evt,
	input wire logic pon_clear_flag,
	input wire logic dev_clear,
	// command port
	input wire logic cmd_valid,
	input wire sra_pkg::sra_op_e cmd_op,
	input wire logic [2:0] cmd_sel,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_line_first,
	// response
	output logic resp_valid,
	output logic [15:0] resp_data,
	// measurement conditions
	input wire logic ext_ref_in,
	input wire logic limit1_fail,
	input wire logic limit2_fail,
	input wire logic if_overload,
	// event sources
	input wire logic evt_opc,
	input wire logic evt_qye,
	input wire logic evt_dde,
	input wire logic evt_exe,
	input wire logic evt_cme,
	input wire logic err_push,
	input wire logic [15:0] err_code,
	input wire logic mav,
	// serial poll
	input wire logic spoll_req,
	output logic spoll_valid,
	output logic [7:0] spoll_byte,
	// status and housekeeping outputs
	output logic srq,
	output logic overload_display_flag,
	output logic obuf_clear,
	output logic ibuf_clear,
	output logic cmd_abort,
	output logic settings_reset
);
	localparam int NQ = sra_pkg::NUM_QREG;

	generate
		if (NQ != 5) begin : g_bad_nq
			$error("register count must be five");
		end
	endgenerate

	typedef struct packed {
		logic [7:0] ese;
		logic [7:0] sre;
		logic [7:0] ppe;
		logic [7:0] esr;
		logic resp_valid;
		logic [15:0] resp_data;
		logic spoll_valid;
		logic [7:0] spoll_byte;
		logic srq;
		logic ovl;
		logic obuf_clear;
		logic ibuf_clear;
		logic cmd_abort;
		logic settings_reset;
	} sra_top_s;

	sra_top_s st_r;
	sra_top_s st_nxt;

	// command decode
	logic is_q_sel;
	logic op_cls;
	logic pon_full;
	logic preset_all;
	logic clr_events;
	logic line_cmd;

	// sub-register wiring
	logic [15:0] q_cin [NQ];
	logic [15:0] q_cond [NQ];
	logic [15:0] q_evt [NQ];
	logic [15:0] q_enab [NQ];
	logic [15:0] q_ptr [NQ];
	logic [15:0] q_ntr [NQ];
	logic [NQ-1:0] q_summ;
	logic [NQ-1:0] q_hit;

	// error queue
	logic [15:0] err_head;
	logic err_nonempty;
	logic err_pop;

	// status byte
	logic [7:0] stb_raw;
	logic mss;
	logic [7:0] stb;

	assign is_q_sel = (cmd_sel <= sra_pkg::SEL_OPER);
	assign op_cls = cmd_valid && cmd_op == sra_pkg::OP_CLS;
	assign pon_full = por_evt && pon_clear_flag;
	assign preset_all = pon_full ||
		(cmd_valid && cmd_op == sra_pkg::OP_STAT_PRESET);
	// (R13) only cls and flagged power-on
	assign clr_events = op_cls || pon_full;
	assign line_cmd = cmd_valid && cmd_line_first &&
		(cmd_op == sra_pkg::OP_RST || cmd_op == sra_pkg::OP_SYS_PRESET ||
		cmd_op == sra_pkg::OP_STAT_PRESET || cmd_op == sra_pkg::OP_CLS);

	// (R1) external reference condition
	assign q_cin[sra_pkg::SEL_FREQ] =
		16'(ext_ref_in) << sra_pkg::FREQ_EXT_REF_BIT;
	// (R3) limit line 1 condition
	// (R4) limit line 2 condition
	assign q_cin[sra_pkg::SEL_LIM] =
		(16'(limit1_fail) << sra_pkg::LIM1_FAIL_BIT) |
		(16'(limit2_fail) << sra_pkg::LIM2_FAIL_BIT);
	// (R5) if overload condition
	assign q_cin[sra_pkg::SEL_POW] =
		16'(if_overload) << sra_pkg::POW_IF_OVL_BIT;
	// (R22) summaries feed next level
	assign q_cin[sra_pkg::SEL_QUES] =
		(16'(q_summ[sra_pkg::SEL_POW]) << sra_pkg::QUES_POW_BIT) |
		(16'(q_summ[sra_pkg::SEL_FREQ]) << sra_pkg::QUES_FREQ_BIT) |
		(16'(q_summ[sra_pkg::SEL_LIM]) << sra_pkg::QUES_LIM_BIT);
	assign q_cin[sra_pkg::SEL_OPER] = 16'h0000;

	generate
		for (genvar g = 0; g < NQ; g++) begin : g_qreg
			assign q_hit[g] = cmd_valid && is_q_sel && cmd_sel == 3'(g);
			sra_qreg #(
				.VALID(sra_pkg::QREG_MASK[g])
			) u_qreg (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.ce(ce),
				.cond_in(q_cin[g]),
				.wr_enab(q_hit[g] && cmd_op == sra_pkg::OP_ENAB_W),
				.wr_ptr(q_hit[g] && cmd_op == sra_pkg::OP_PTR_W),
				.wr_ntr(q_hit[g] && cmd_op == sra_pkg::OP_NTR_W),
				.wdata(cmd_wdata),
				.rd_event(q_hit[g] && cmd_op == sra_pkg::OP_EVENT_Q),
				.preset(preset_all),
				.clr_event(clr_events),
				.cond(q_cond[g]),
				.event_bits(q_evt[g]),
				.enab(q_enab[g]),
				.ptr(q_ptr[g]),
				.ntr(q_ntr[g]),
				.summ(q_summ[g])
			);
		end
	endgenerate

	assign err_pop = cmd_valid && cmd_op == sra_pkg::OP_ERR_Q;

	sra_errq #(
		.DEPTH(ERRQ_DEPTH)
	) u_errq (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.ce(ce),
		// (R16) queue cleared every power-on
		.clr(op_cls || por_evt),
		.push(err_push),
		.push_code(err_code),
		.pop(err_pop),
		.head_code(err_head),
		.nonempty(err_nonempty)
	);

	always_comb begin
		stb_raw = 8'h00;
		stb_raw[sra_pkg::STB_ERRQ_BIT] = err_nonempty;
		stb_raw[sra_pkg::STB_QUES_BIT] = q_summ[sra_pkg::SEL_QUES];
		stb_raw[sra_pkg::STB_MAV_BIT] = mav;
		// (R7) esb from enabled events
		stb_raw[sra_pkg::STB_ESB_BIT] = |(st_r.esr & st_r.ese);
		stb_raw[sra_pkg::STB_OPER_BIT] = q_summ[sra_pkg::SEL_OPER];
		// (R6) enabled summary request
		mss = |(stb_raw & st_r.sre & sra_pkg::SRQ_SRC_MASK);
		stb = stb_raw;
		stb[sra_pkg::STB_RQS_BIT] = mss;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.resp_valid = 1'b0;
		st_nxt.resp_data = 16'h0000;
		// (R13) esr cleared, new events win
		if (clr_events ||
			(cmd_valid && cmd_op == sra_pkg::OP_ESR_Q)) begin
			st_nxt.esr = sra_pkg::MASK8_CLEAR;
		end
		st_nxt.esr[sra_pkg::ESR_OPC_BIT] =
			st_nxt.esr[sra_pkg::ESR_OPC_BIT] | evt_opc;
		st_nxt.esr[sra_pkg::ESR_QYE_BIT] =
			st_nxt.esr[sra_pkg::ESR_QYE_BIT] | evt_qye;
		st_nxt.esr[sra_pkg::ESR_DDE_BIT] =
			st_nxt.esr[sra_pkg::ESR_DDE_BIT] | evt_dde;
		st_nxt.esr[sra_pkg::ESR_EXE_BIT] =
			st_nxt.esr[sra_pkg::ESR_EXE_BIT] | evt_exe;
		st_nxt.esr[sra_pkg::ESR_CME_BIT] =
			st_nxt.esr[sra_pkg::ESR_CME_BIT] | evt_cme;
		st_nxt.esr[sra_pkg::ESR_PON_BIT] =
			st_nxt.esr[sra_pkg::ESR_PON_BIT] | por_evt;
		// (R9) queries return raw pattern
		if (cmd_valid) begin
			unique case (cmd_op)
				sra_pkg::OP_COND_Q: begin
					st_nxt.resp_valid = 1'b1;
					if (is_q_sel) begin
						st_nxt.resp_data = q_cond[cmd_sel];
					end
				end
				// (R21) event value before its clear
				sra_pkg::OP_EVENT_Q: begin
					st_nxt.resp_valid = 1'b1;
					if (is_q_sel) begin
						st_nxt.resp_data = q_evt[cmd_sel];
					end
				end
				sra_pkg::OP_ENAB_Q: begin
					st_nxt.resp_valid = 1'b1;
					if (is_q_sel) begin
						st_nxt.resp_data = q_enab[cmd_sel];
					end
				end
				sra_pkg::OP_PTR_Q: begin
					st_nxt.resp_valid = 1'b1;
					if (is_q_sel) begin
						st_nxt.resp_data = q_ptr[cmd_sel];
					end
				end
				sra_pkg::OP_NTR_Q: begin
					st_nxt.resp_valid = 1'b1;
					if (is_q_sel) begin
						st_nxt.resp_data = q_ntr[cmd_sel];
					end
				end
				sra_pkg::OP_ESE_W: begin
					st_nxt.ese = cmd_wdata[7:0];
				end
				sra_pkg::OP_SRE_W: begin
					st_nxt.sre = cmd_wdata[7:0];
				end
				sra_pkg::OP_PPE_W: begin
					st_nxt.ppe = cmd_wdata[7:0];
				end
				sra_pkg::OP_ESE_Q: begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data = {8'h00, st_r.ese};
				end
				sra_pkg::OP_SRE_Q: begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data = {8'h00, st_r.sre};
				end
				sra_pkg::OP_PPE_Q: begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data = {8'h00, st_r.ppe};
				end
				sra_pkg::OP_STB_Q: begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data = {8'h00, stb};
				end
				sra_pkg::OP_ESR_Q: begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data = {8'h00, st_r.esr};
				end
				// (R10) pop one entry
				sra_pkg::OP_ERR_Q: begin
					st_nxt.resp_valid = 1'b1;
					st_nxt.resp_data = err_head;
				end
				default: begin
				end
			endcase
		end
		// (R16) masks cleared at flagged power-on
		if (pon_full) begin
			st_nxt.ese = sra_pkg::MASK8_CLEAR;
			st_nxt.sre = sra_pkg::MASK8_CLEAR;
			st_nxt.ppe = sra_pkg::MASK8_CLEAR;
		end
		// (R6) registered service request
		st_nxt.srq = mss;
		// (R12) status byte by poll message
		st_nxt.spoll_valid = spoll_req;
		st_nxt.spoll_byte = spoll_req ? stb : st_r.spoll_byte;
		// (R5) overload display indication
		st_nxt.ovl = if_overload;
		// (R17) flush on power-on or clear
		// (R18) flush at line start on rst, sys preset, stat preset or cls
		st_nxt.obuf_clear = por_evt || dev_clear || line_cmd;
		st_nxt.ibuf_clear = por_evt || dev_clear;
		st_nxt.cmd_abort = por_evt || dev_clear;
		// (R19) settings only by reset commands
		// (R20) reset leaves status untouched
		st_nxt.settings_reset = cmd_valid &&
			(cmd_op == sra_pkg::OP_RST || cmd_op == sra_pkg::OP_SYS_PRESET);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign resp_valid = st_r.resp_valid;
	assign resp_data = st_r.resp_data;
	assign spoll_valid = st_r.spoll_valid;
	assign spoll_byte = st_r.spoll_byte;
	assign srq = st_r.srq;
	assign overload_display_flag = st_r.ovl;
	assign obuf_clear = st_r.obuf_clear;
	assign ibuf_clear = st_r.ibuf_clear;
	assign cmd_abort = st_r.cmd_abort;
	assign settings_reset = st_r.settings_reset;
endmodule

// *** testbench/sra_asserts.sv ***
module sra_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// inputs watched
	input wire logic por_evt,
	input wire logic dev_clear,
	input wire logic cmd_valid,
	input wire sra_pkg::sra_op_e cmd_op,
	input wire logic [2:0] cmd_sel,
	input wire logic cmd_line_first,
	input wire logic if_overload,
	input wire logic spoll_req,
	// outputs watched
	input wire logic resp_valid,
	input wire logic [15:0] resp_data,
	input wire logic spoll_valid,
	input wire logic [7:0] spoll_byte,
	input wire logic srq,
	input wire logic overload_display_flag,
	input wire logic obuf_clear,
	input wire logic ibuf_clear,
	input wire logic cmd_abort,
	input wire logic settings_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// sub-register selected by a register-part query in the previous cycle, else 7
	logic [2:0] qsel_r;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			qsel_r <= 3'h7;
		end else if (cmd_valid && ce && cmd_op inside
			{[sra_pkg::OP_COND_Q:sra_pkg::OP_NTR_Q]}) begin
			qsel_r <= cmd_sel;
		end else begin
			qsel_r <= 3'h7;
		end
	end
	a_ovl_display: assert property (
		ce |=> overload_display_flag == $past(if_overload))
		else $error("overload display out of step");
	a_srq_source: assert property (
		spoll_valid && (spoll_byte & 8'hBC) == 8'h00 |-> !srq)
		else $error("service request without enabled source");
	a_query_answer: assert property (
		ce && cmd_valid && cmd_op inside
		{sra_pkg::OP_COND_Q, sra_pkg::OP_EVENT_Q, sra_pkg::OP_ERR_Q}
		|=> resp_valid)
		else $error("query without answer");
	a_top_bit_zero: assert property (
		resp_valid && qsel_r inside {3'h1, 3'h2, 3'h3} |-> !resp_data[15])
		else $error("bit 15 read as one");
	a_unused_lim: assert property (
		resp_valid && qsel_r == 3'h2
		|-> (resp_data & ~sra_pkg::MASK_LIM) == 16'h0000)
		else $error("unused limit bit read as one");
	a_dclr_flush: assert property (
		ce && dev_clear |=> obuf_clear && ibuf_clear && cmd_abort)
		else $error("device clear did not flush");
	a_line_clear: assert property (
		ce && cmd_valid && cmd_line_first && cmd_op inside
		{sra_pkg::OP_CLS, sra_pkg::OP_STAT_PRESET, sra_pkg::OP_RST}
		|=> obuf_clear)
		else $error("output buffer kept at line start");
	a_no_stray_clear: assert property (
		ce && cmd_valid && !cmd_line_first && !dev_clear && !por_evt
		|=> !obuf_clear)
		else $error("output buffer cleared mid line");
	a_dclr_keep: assert property (
		ce && dev_clear && !cmd_valid |=> !settings_reset)
		else $error("device clear touched settings");
	a_spoll_answer: assert property (
		ce && spoll_req |=> spoll_valid)
		else $error("serial poll without answer");
endmodule

bind sra_top sra_asserts u_chk (.ref_clk, .nrst, .ce, .por_evt,
	.dev_clear, .cmd_valid, .cmd_op, .cmd_sel, .cmd_line_first,
	.if_overload, .spoll_req, .resp_valid, .resp_data, .spoll_valid,
	.spoll_byte, .srq, .overload_display_flag, .obuf_clear,
	.ibuf_clear, .cmd_abort, .settings_reset);

// *** testbench/sra_host.sv ***
module sra_host (
	// clock
	input wire logic ref_clk,
	// command port
	output logic cmd_valid,
	output sra_pkg::sra_op_e cmd_op,
	output logic [2:0] cmd_sel,
	output logic [15:0] cmd_wdata,
	output logic cmd_line_first,
	input wire logic resp_valid,
	input wire logic [15:0] resp_data,
	// serial poll
	output logic spoll_req,
	input wire logic spoll_valid,
	input wire logic [7:0] spoll_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_valid = 1'b0;
		cmd_op = sra_pkg::OP_NOP;
		cmd_sel = 3'h0;
		cmd_wdata = 16'h0000;
		cmd_line_first = 1'b0;
		spoll_req = 1'b0;
	end
	// one command; answer taken while it stands
	task automatic send(input sra_pkg::sra_op_e op, input logic [2:0] sel,
		input logic [15:0] wd, input logic first, output logic [16:0] rd);
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_sel = sel;
		cmd_wdata = wd;
		cmd_line_first = first;
		@(negedge ref_clk);
		rd = {resp_valid, resp_data};
		cmd_valid = 1'b0;
		cmd_line_first = 1'b0;
		cmd_wdata = ~wd;
	endtask
	task automatic poll(output logic [8:0] sb);
		@(negedge ref_clk);
		spoll_req = 1'b1;
		@(negedge ref_clk);
		sb = {spoll_valid, spoll_byte};
		spoll_req = 1'b0;
	endtask
endmodule

// *** testbench/sra_top_tb.sv ***
module sra_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, nrst, pon_flag, ext_ref, ovl, mav, ovl_disp;
	logic [7:0] pv;
	logic [1:0] lim;
	logic [15:0] err_code, cmd_wdata, resp_data;
	logic cmd_valid, cmd_first, resp_valid, spoll_req, spoll_valid, srq;
	sra_pkg::sra_op_e cmd_op;
	logic [2:0] cmd_sel;
	logic [7:0] spoll_byte;
	logic [3:0] clr;
	logic [16:0] r;
	logic [8:0] sb;
	int miscompares, comparisons;
	sra_top dut (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1),
		.por_evt(pv[5]), .pon_clear_flag(pon_flag), .dev_clear(pv[6]),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sel(cmd_sel),
		.cmd_wdata(cmd_wdata), .cmd_line_first(cmd_first),
		.resp_valid(resp_valid), .resp_data(resp_data),
		.ext_ref_in(ext_ref), .limit1_fail(lim[0]), .limit2_fail(lim[1]),
		.if_overload(ovl), .evt_opc(pv[0]), .evt_qye(pv[1]),
		.evt_dde(pv[2]), .evt_exe(pv[3]), .evt_cme(pv[4]),
		.err_push(pv[7]), .err_code(err_code), .mav(mav),
		.spoll_req(spoll_req), .spoll_valid(spoll_valid),
		.spoll_byte(spoll_byte), .srq(srq), .overload_display_flag(ovl_disp),
		.obuf_clear(clr[3]), .ibuf_clear(clr[2]), .cmd_abort(clr[1]),
		.settings_reset(clr[0]));
	sra_host host (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
		.cmd_line_first(cmd_first), .resp_valid(resp_valid),
		.resp_data(resp_data), .spoll_req(spoll_req),
		.spoll_valid(spoll_valid), .spoll_byte(spoll_byte));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic pulse(input int i);
		@(negedge ref_clk);
		pv[i] = 1'b1;
		@(negedge ref_clk);
		pv[i] = 1'b0;
	endtask
	task automatic q(input sra_pkg::sra_op_e op, input logic [2:0] sel,
		input logic [15:0] exp);
		logic [16:0] rd;
		host.send(op, sel, 16'h0000, 1'b0, rd);
		chk(rd, {1'b1, exp});
	endtask
	task automatic wr(input sra_pkg::sra_op_e op, input logic [2:0] sel,
		input logic [15:0] d);
		logic [16:0] rd;
		host.send(op, sel, d, 1'b0, rd);
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		test_done();
	end
	initial begin
		nrst = 1'b0;
		{pv, ext_ref, lim, ovl, mav} = '0;
		pon_flag = 1'b1;
		err_code = 16'h0000;
		cyc(10);
		nrst = 1'b1;
		pulse(5);
		q(sra_pkg::OP_ESR_Q, 3'h0, 16'h0080);
		q(sra_pkg::OP_ESR_Q, 3'h0, 16'h0000);
		q(sra_pkg::OP_ENAB_Q, 3'h2, 16'h0000);
		q(sra_pkg::OP_PTR_Q, 3'h2, sra_pkg::MASK_LIM);
		q(sra_pkg::OP_NTR_Q, 3'h2, 16'h0000);
		q(sra_pkg::OP_SRE_Q, 3'h0, 16'h0000);
		ext_ref = 1'b1;
		cyc(3);
		q(sra_pkg::OP_COND_Q, 3'h1, 16'h0100);
		wr(sra_pkg::OP_ENAB_W, 3'h1, 16'hFFFF);
		q(sra_pkg::OP_ENAB_Q, 3'h1, 16'h0100);
		q(sra_pkg::OP_EVENT_Q, 3'h1, 16'h0100);
		q(sra_pkg::OP_EVENT_Q, 3'h1, 16'h0000);
		q(sra_pkg::OP_COND_Q, 3'h1, 16'h0100);
		for (int i = 0; i < 2; i++) begin
			lim[i] = 1'b1;
			cyc(3);
			q(sra_pkg::OP_EVENT_Q, 3'h2, 16'h0001 << i);
		end
		ovl = 1'b1;
		cyc(3);
		q(sra_pkg::OP_COND_Q, 3'h3, 16'h0004);
		chk(17'(ovl_disp), 17'h1);
		wr(sra_pkg::OP_ENAB_W, 3'h3, 16'h0004);
		wr(sra_pkg::OP_ENAB_W, 3'h0, 16'h0008);
		wr(sra_pkg::OP_SRE_W, 3'h0, 16'h00FF);
		wr(sra_pkg::OP_ESE_W, 3'h0, 16'h00FF);
		cyc(3);
		chk(17'(srq), 17'h1);
		host.poll(sb);
		chk(17'(sb), 17'h148);
		q(sra_pkg::OP_STB_Q, 3'h0, 16'h0048);
		wr(sra_pkg::OP_CLS, 3'h0, 16'h0000);
		wr(sra_pkg::OP_SRE_W, 3'h0, 16'h0020);
		wr(sra_pkg::OP_ESE_W, 3'h0, 16'h0001);
		cyc(3);
		chk(17'(srq), 17'h0);
		pulse(0);
		cyc(3);
		chk(17'(srq), 17'h1);
		host.poll(sb);
		chk(17'(sb), 17'h160);
		q(sra_pkg::OP_ERR_Q, 3'h0, 16'h0000);
		err_code = 16'hFF9C;
		pulse(7);
		err_code = 16'h0101;
		pulse(7);
		q(sra_pkg::OP_ERR_Q, 3'h0, 16'hFF9C);
		q(sra_pkg::OP_ERR_Q, 3'h0, 16'h0101);
		q(sra_pkg::OP_ERR_Q, 3'h0, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			pulse(i);
			q(sra_pkg::OP_ESR_Q, 3'h0, 16'h0001 << (i ? i + 1 : 0));
		end
		wr(sra_pkg::OP_NTR_W, 3'h2, 16'h0003);
		host.send(sra_pkg::OP_RST, 3'h0, 16'h0000, 1'b1, r);
		chk(17'(clr), 17'h9);
		q(sra_pkg::OP_ESE_Q, 3'h0, 16'h0001);
		q(sra_pkg::OP_NTR_Q, 3'h2, 16'h0003);
		wr(sra_pkg::OP_STAT_PRESET, 3'h0, 16'h0000);
		q(sra_pkg::OP_NTR_Q, 3'h2, 16'h0000);
		q(sra_pkg::OP_ENAB_Q, 3'h0, 16'h0000);
		q(sra_pkg::OP_SRE_Q, 3'h0, 16'h0020);
		pulse(6);
		chk(17'(clr), 17'hE);
		q(sra_pkg::OP_ESE_Q, 3'h0, 16'h0001);
		pon_flag = 1'b0;
		pulse(4);
		err_code = 16'h0202;
		pulse(7);
		pulse(5);
		chk(17'(clr), 17'hE);
		host.send(sra_pkg::OP_ESR_Q, 3'h0, 16'h0000, 1'b0, r);
		chk(r, 17'h100A0);
		q(sra_pkg::OP_ERR_Q, 3'h0, 16'h0000);
		q(sra_pkg::OP_SRE_Q, 3'h0, 16'h0020);
		test_done();
	end
endmodule
